// ===== rtl/cmoh_message_handler.sv
// cmoh_message_handler: message objects, interface register set, filter
// assumes an on-chip protocol core on clk and an apb master
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
module cmoh_message_handler #(
    parameter int NUM_OBJ = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxValid,
    input wire cmoh_pkg::cmoh_frame_s rxFrame,
    output logic rxReady,
    input wire logic txLoadReady,
    output logic txStart,
    output cmoh_pkg::cmoh_frame_s txFrame,
    input wire logic txDone,
    input wire logic txFail,
    output logic [NUM_OBJ-1:0] irqPendingVec
);
    import cmoh_pkg::*;

    localparam int IW = $clog2(NUM_OBJ);

    // ==========
    // reset release
    logic rstMeta;
    logic rstN;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // ==========
    // apb decode
    cmoh_obj_s mem [NUM_OBJ];
    cmoh_obj_s next_mem [NUM_OBJ];
    cmoh_obj_s ifObj;
    cmoh_obj_s next_ifObj;
    logic [7:0] ifCmsk;
    logic [7:0] next_ifCmsk;
    logic [31:0] next_prdata;
    logic [31:0] rdVal;
    logic addrOk;
    logic wrAcc;
    logic xferGo;
    logic [IW-1:0] xferIdx;
    cmoh_scan_e scanSt;
    cmoh_scan_e next_scanSt;
    logic [IW-1:0] scanIdx;
    logic [IW-1:0] next_scanIdx;
    cmoh_frame_s scanFrame;
    cmoh_frame_s next_scanFrame;
    logic match;
    cmoh_tx_e txSt;
    cmoh_tx_e next_txSt;
    logic [IW-1:0] txObj;
    logic [IW-1:0] next_txObj;
    logic txRenew;
    logic next_txRenew;
    logic next_txStart;
    cmoh_frame_s next_txFrame;
    logic [IW-1:0] pick;
    logic pickAny;
    logic txLoad;
    logic txEnd;

    assign pready = 1'b1;
    assign addrOk = (paddr <= OFS_STAT) && (paddr[1:0] == 2'b00);
    assign pslverr = psel & penable & ~addrOk;
    assign wrAcc = psel & penable & pwrite & addrOk;
    assign xferGo = wrAcc && (paddr == OFS_CRQ) && (pwdata[5:0] != 6'h00)
                    && ({26'h0, pwdata[5:0]} <= 32'(NUM_OBJ));
    assign xferIdx = IW'(pwdata[5:0] - 6'h01);

    // ==========
    // register read view
    always_comb begin
        rdVal = 32'h00000000;
        unique case (paddr)
            OFS_CMSK: rdVal[7:0] = ifCmsk;
            OFS_MSK1: rdVal[15:0] = ifObj.msk[15:0];
            OFS_MSK2: begin
                rdVal[12:0] = ifObj.msk[28:16];
                rdVal[M2_XTD] = ifObj.maskExtendedFlag;
                rdVal[M2_DIR] = ifObj.maskDirectionFlag;
            end
            OFS_ARB1: rdVal[15:0] = ifObj.id[15:0];
            OFS_ARB2: begin
                rdVal[12:0] = ifObj.id[28:16];
                rdVal[A2_VALID] = ifObj.objectValid;
                rdVal[A2_XTD] = ifObj.xtd;
                rdVal[A2_DIR] = ifObj.dir;
            end
            OFS_MCTL: begin
                rdVal[3:0] = ifObj.dlc;
                rdVal[MC_NEW_DATA_FLAG] = ifObj.newDataFlag;
                rdVal[MC_LOST] = ifObj.messageLostFlag;
                rdVal[MC_IRQ] = ifObj.irqPending;
                rdVal[MC_USE_ACCEPTANCE_MASK] = ifObj.useAcceptanceMask;
                rdVal[MC_TRANSMIT_IRQ_ENABLE] = ifObj.transmitIrqEnable;
                rdVal[MC_RECEIVE_IRQ_ENABLE] = ifObj.receiveIrqEnable;
                rdVal[MC_REMOTE_ANSWER_ENABLE] = ifObj.remoteAnswerEnable;
                rdVal[MC_TXRQ] = ifObj.transmitRequest;
                rdVal[MC_EOB] = ifObj.endOfBuffer;
            end
            OFS_DL1: rdVal[15:0] = ifObj.data[15:0];
            OFS_DL2: rdVal[15:0] = ifObj.data[31:16];
            OFS_DH1: rdVal[15:0] = ifObj.data[47:32];
            OFS_DH2: rdVal[15:0] = ifObj.data[63:48];
            OFS_STAT: rdVal[7:0] = {scanSt == SC_RUN, txSt == TX_BUSY, 1'b0, 5'(txObj)};
            default: rdVal = 32'h00000000;
        endcase
    end

    // ==========
    // interface register set
    always_comb begin
        next_ifObj = ifObj;
        next_ifCmsk = ifCmsk;
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            next_prdata = rdVal;
        end
        if (wrAcc) begin
            unique case (paddr)
                OFS_CMSK: next_ifCmsk = pwdata[7:0];
                OFS_MSK1: next_ifObj.msk[15:0] = pwdata[15:0];
                OFS_MSK2: begin
                    next_ifObj.msk[28:16] = pwdata[12:0];
                    next_ifObj.maskExtendedFlag = pwdata[M2_XTD];
                    next_ifObj.maskDirectionFlag = pwdata[M2_DIR];
                end
                OFS_ARB1: next_ifObj.id[15:0] = pwdata[15:0];
                OFS_ARB2: begin
                    next_ifObj.id[28:16] = pwdata[12:0];
                    next_ifObj.objectValid = pwdata[A2_VALID];
                    next_ifObj.xtd = pwdata[A2_XTD];
                    next_ifObj.dir = pwdata[A2_DIR];
                end
                OFS_MCTL: begin
                    next_ifObj.dlc = pwdata[3:0];
                    next_ifObj.newDataFlag = pwdata[MC_NEW_DATA_FLAG];
                    next_ifObj.messageLostFlag = pwdata[MC_LOST];
                    next_ifObj.irqPending = pwdata[MC_IRQ];
                    next_ifObj.useAcceptanceMask = pwdata[MC_USE_ACCEPTANCE_MASK];
                    next_ifObj.transmitIrqEnable = pwdata[MC_TRANSMIT_IRQ_ENABLE];
                    next_ifObj.receiveIrqEnable = pwdata[MC_RECEIVE_IRQ_ENABLE];
                    next_ifObj.remoteAnswerEnable = pwdata[MC_REMOTE_ANSWER_ENABLE];
                    next_ifObj.transmitRequest = pwdata[MC_TXRQ];
                    next_ifObj.endOfBuffer = pwdata[MC_EOB];
                end
                OFS_DL1: next_ifObj.data[15:0] = pwdata[15:0];
                OFS_DL2: next_ifObj.data[31:16] = pwdata[15:0];
                OFS_DH1: next_ifObj.data[47:32] = pwdata[15:0];
                OFS_DH2: next_ifObj.data[63:48] = pwdata[15:0];
                default: next_ifCmsk = ifCmsk;
            endcase
        end
        if (xferGo && !ifCmsk[CM_WR]) begin
            if (ifCmsk[CM_MASK]) begin
                next_ifObj.msk = mem[xferIdx].msk;
                next_ifObj.maskExtendedFlag = mem[xferIdx].maskExtendedFlag;
                next_ifObj.maskDirectionFlag = mem[xferIdx].maskDirectionFlag;
            end
            if (ifCmsk[CM_ARB]) begin
                next_ifObj.id = mem[xferIdx].id;
                next_ifObj.xtd = mem[xferIdx].xtd;
                next_ifObj.dir = mem[xferIdx].dir;
                next_ifObj.objectValid = mem[xferIdx].objectValid;
            end
            if (ifCmsk[CM_CTRL]) begin
                next_ifObj.dlc = mem[xferIdx].dlc;
                next_ifObj.newDataFlag = mem[xferIdx].newDataFlag;
                next_ifObj.messageLostFlag = mem[xferIdx].messageLostFlag;
                next_ifObj.irqPending = mem[xferIdx].irqPending;
                next_ifObj.useAcceptanceMask = mem[xferIdx].useAcceptanceMask;
                next_ifObj.transmitIrqEnable = mem[xferIdx].transmitIrqEnable;
                next_ifObj.receiveIrqEnable = mem[xferIdx].receiveIrqEnable;
                next_ifObj.remoteAnswerEnable = mem[xferIdx].remoteAnswerEnable;
                next_ifObj.transmitRequest = mem[xferIdx].transmitRequest;
                next_ifObj.endOfBuffer = mem[xferIdx].endOfBuffer;
            end
            if (ifCmsk[CM_DATAL]) begin
                next_ifObj.data[31:0] = mem[xferIdx].data[31:0];
            end
            if (ifCmsk[CM_DATAH]) begin
                next_ifObj.data[63:32] = mem[xferIdx].data[63:32];
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ifObj <= '0;
            ifCmsk <= RST_CMSK;
            prdata <= RST_RDATA;
        end else begin
            ifObj <= next_ifObj;
            ifCmsk <= next_ifCmsk;
            prdata <= next_prdata;
        end
    end

    // ==========
    // acceptance filter
    logic [28:0] care;

    always_comb begin
        care = mem[scanIdx].useAcceptanceMask ? mem[scanIdx].msk : '1;
        if (!mem[scanIdx].xtd) begin
            care[17:0] = '0;
        end
        match = (scanSt == SC_RUN) && mem[scanIdx].objectValid
                && (((scanFrame.id ^ mem[scanIdx].id) & care) == '0)
                && ((mem[scanIdx].useAcceptanceMask
                     && !mem[scanIdx].maskExtendedFlag)
                    || (scanFrame.xtd == mem[scanIdx].xtd))
                && ((mem[scanIdx].useAcceptanceMask
                     && !mem[scanIdx].maskDirectionFlag)
                    || (scanFrame.rtr == mem[scanIdx].dir));
    end

    // ==========
    // object scan
    assign rxReady = (scanSt == SC_IDLE);

    always_comb begin
        next_scanSt = scanSt;
        next_scanIdx = scanIdx;
        next_scanFrame = scanFrame;
        unique case (scanSt)
            SC_IDLE: begin
                if (rxValid) begin
                    next_scanFrame = rxFrame;
                    next_scanIdx = '0;
                    next_scanSt = SC_RUN;
                end
            end
            SC_RUN: begin
                if (match || (scanIdx == IW'(NUM_OBJ - 1))) begin
                    next_scanSt = SC_IDLE;
                end else begin
                    next_scanIdx = scanIdx + 1'b1;
                end
            end
            default: next_scanSt = SC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            scanSt <= SC_IDLE;
            scanIdx <= '0;
            scanFrame <= '0;
        end else begin
            scanSt <= next_scanSt;
            scanIdx <= next_scanIdx;
            scanFrame <= next_scanFrame;
        end
    end

    // ==========
    // transmit selection
    always_comb begin
        pick = '0;
        pickAny = 1'b0;
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
            if (mem[i].objectValid && mem[i].transmitRequest) begin
                pick = IW'(i);
                pickAny = 1'b1;
            end
        end
    end

    assign txLoad = (txSt == TX_IDLE) && txLoadReady && pickAny && !xferGo;
    assign txEnd = (txSt == TX_BUSY) && (txDone || txFail);

    always_comb begin
        next_txSt = txSt;
        next_txObj = txObj;
        next_txRenew = txRenew;
        next_txStart = txLoad;
        next_txFrame = txFrame;
        if (txLoad) begin
            next_txSt = TX_BUSY;
            next_txObj = pick;
            next_txRenew = 1'b0;
            next_txFrame.id = mem[pick].id;
            next_txFrame.xtd = mem[pick].xtd;
            next_txFrame.rtr = !mem[pick].dir;
            next_txFrame.dlc = mem[pick].dlc;
            next_txFrame.data = mem[pick].data;
        end else if (txEnd) begin
            next_txSt = TX_IDLE;
        end
        if ((txSt == TX_BUSY) && xferGo && ifCmsk[CM_WR]
            && ifCmsk[CM_NEW_DATA_FLAG] && (xferIdx == txObj)) begin
            next_txRenew = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            txSt <= TX_IDLE;
            txObj <= '0;
            txRenew <= 1'b0;
            txStart <= 1'b0;
            txFrame <= '0;
        end else begin
            txSt <= next_txSt;
            txObj <= next_txObj;
            txRenew <= next_txRenew;
            txStart <= next_txStart;
            txFrame <= next_txFrame;
        end
    end

    // ==========
    // message memory
    always_comb begin
        next_mem = mem;
        if (xferGo && ifCmsk[CM_WR]) begin
            if (ifCmsk[CM_MASK]) begin
                next_mem[xferIdx].msk = ifObj.msk;
                next_mem[xferIdx].maskExtendedFlag = ifObj.maskExtendedFlag;
                next_mem[xferIdx].maskDirectionFlag = ifObj.maskDirectionFlag;
            end
            if (ifCmsk[CM_ARB]) begin
                next_mem[xferIdx].id = ifObj.id;
                next_mem[xferIdx].xtd = ifObj.xtd;
                next_mem[xferIdx].dir = ifObj.dir;
                next_mem[xferIdx].objectValid = ifObj.objectValid;
            end
            if (ifCmsk[CM_CTRL]) begin
                next_mem[xferIdx].dlc = ifObj.dlc;
                next_mem[xferIdx].newDataFlag = ifObj.newDataFlag;
                next_mem[xferIdx].messageLostFlag = ifObj.messageLostFlag;
                next_mem[xferIdx].irqPending = ifObj.irqPending;
                next_mem[xferIdx].useAcceptanceMask = ifObj.useAcceptanceMask;
                next_mem[xferIdx].transmitIrqEnable = ifObj.transmitIrqEnable;
                next_mem[xferIdx].receiveIrqEnable = ifObj.receiveIrqEnable;
                next_mem[xferIdx].remoteAnswerEnable = ifObj.remoteAnswerEnable;
                next_mem[xferIdx].transmitRequest = ifObj.transmitRequest;
                next_mem[xferIdx].endOfBuffer = ifObj.endOfBuffer;
            end
            if (ifCmsk[CM_DATAL]) begin
                next_mem[xferIdx].data[31:0] = ifObj.data[31:0];
            end
            if (ifCmsk[CM_DATAH]) begin
                next_mem[xferIdx].data[63:32] = ifObj.data[63:32];
            end
            if (ifCmsk[CM_NEW_DATA_FLAG]) begin
                next_mem[xferIdx].transmitRequest = 1'b1;
                next_mem[xferIdx].newDataFlag = 1'b1;
            end
        end else if (xferGo) begin
            if (ifCmsk[CM_CLRIRQ]) begin
                next_mem[xferIdx].irqPending = 1'b0;
            end
            if (ifCmsk[CM_NEW_DATA_FLAG]) begin
                next_mem[xferIdx].newDataFlag = 1'b0;
            end
        end
        if (txLoad) begin
            next_mem[pick].newDataFlag = 1'b0;
        end
        if ((txSt == TX_BUSY) && txDone) begin
            if (!txRenew) begin
                next_mem[txObj].transmitRequest = 1'b0;
            end
            if (mem[txObj].transmitIrqEnable) begin
                next_mem[txObj].irqPending = 1'b1;
            end
        end
        if (match && !scanFrame.rtr) begin
            next_mem[scanIdx].id = scanFrame.id;
            if (!scanFrame.xtd) begin
                next_mem[scanIdx].id[STD_LSB-1:0] = '0;
            end
            next_mem[scanIdx].xtd = scanFrame.xtd;
            next_mem[scanIdx].dlc = scanFrame.dlc;
            next_mem[scanIdx].data = scanFrame.data;
            next_mem[scanIdx].newDataFlag = 1'b1;
            if (mem[scanIdx].newDataFlag) begin
                next_mem[scanIdx].messageLostFlag = 1'b1;
            end
            if (mem[scanIdx].receiveIrqEnable) begin
                next_mem[scanIdx].irqPending = 1'b1;
            end
            next_mem[scanIdx].transmitRequest = 1'b0;
        end else if (match && mem[scanIdx].dir) begin
            if (mem[scanIdx].remoteAnswerEnable) begin
                next_mem[scanIdx].transmitRequest = 1'b1;
            end else if (mem[scanIdx].useAcceptanceMask) begin
                next_mem[scanIdx].transmitRequest = 1'b0;
                next_mem[scanIdx].id = scanFrame.id;
                next_mem[scanIdx].xtd = scanFrame.xtd;
                next_mem[scanIdx].dlc = scanFrame.dlc;
                next_mem[scanIdx].newDataFlag = 1'b1;
            end
            // otherwise the remote frame leaves no trace
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            for (int i = 0; i < NUM_OBJ; i++) begin
                mem[i] <= '0;
            end
        end else begin
            mem <= next_mem;
        end
    end

    // ==========
    // pending flag view
    generate
        for (genvar g = 0; g < NUM_OBJ; g++) begin : gPend
            assign irqPendingVec[g] = mem[g].irqPending;
        end
    endgenerate

endmodule : cmoh_message_handler

// ===== rtl/cmoh_pkg.sv
// cmoh_pkg: register map, field positions, object and frame types
// assumes a 32-bit apb slave, 32 message objects, same-clock core
package cmoh_pkg;

    // ==========
    // register byte offsets
    localparam logic [7:0] OFS_CMSK = 8'h00;
    localparam logic [7:0] OFS_CRQ = 8'h04;
    localparam logic [7:0] OFS_MSK1 = 8'h08;
    localparam logic [7:0] OFS_MSK2 = 8'h0c;
    localparam logic [7:0] OFS_ARB1 = 8'h10;
    localparam logic [7:0] OFS_ARB2 = 8'h14;
    localparam logic [7:0] OFS_MCTL = 8'h18;
    localparam logic [7:0] OFS_DL1 = 8'h1c;
    localparam logic [7:0] OFS_DL2 = 8'h20;
    localparam logic [7:0] OFS_DH1 = 8'h24;
    localparam logic [7:0] OFS_DH2 = 8'h28;
    localparam logic [7:0] OFS_STAT = 8'h2c;

    // ==========
    // command mask bits
    localparam int CM_WR = 7;
    localparam int CM_MASK = 6;
    localparam int CM_ARB = 5;
    localparam int CM_CTRL = 4;
    localparam int CM_CLRIRQ = 3;
    localparam int CM_NEW_DATA_FLAG = 2;
    localparam int CM_DATAL = 1;
    localparam int CM_DATAH = 0;

    // ==========
    // second mask / arbitration word, message control bits
    localparam int M2_XTD = 15;
    localparam int M2_DIR = 14;
    localparam int A2_VALID = 15;
    localparam int A2_XTD = 14;
    localparam int A2_DIR = 13;
    localparam int MC_NEW_DATA_FLAG = 15;
    localparam int MC_LOST = 14;
    localparam int MC_IRQ = 13;
    localparam int MC_USE_ACCEPTANCE_MASK = 12;
    localparam int MC_TRANSMIT_IRQ_ENABLE = 11;
    localparam int MC_RECEIVE_IRQ_ENABLE = 10;
    localparam int MC_REMOTE_ANSWER_ENABLE = 9;
    localparam int MC_TXRQ = 8;
    localparam int MC_EOB = 7;
    localparam int STD_LSB = 18;
    localparam logic [7:0] RST_CMSK = 8'h00;
    localparam logic [31:0] RST_RDATA = 32'h00000000;

    // ==========
    // types
    typedef struct packed {
        logic [28:0] msk;
        logic maskExtendedFlag;
        logic maskDirectionFlag;
        logic [28:0] id;
        logic xtd;
        logic dir;
        logic objectValid;
        logic newDataFlag;
        logic messageLostFlag;
        logic irqPending;
        logic useAcceptanceMask;
        logic transmitIrqEnable;
        logic receiveIrqEnable;
        logic remoteAnswerEnable;
        logic transmitRequest;
        logic endOfBuffer;
        logic [3:0] dlc;
        logic [63:0] data;
    } cmoh_obj_s;

    typedef struct packed {
        logic [28:0] id;
        logic xtd;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data;
    } cmoh_frame_s;

    typedef enum logic [1:0] {SC_IDLE = 2'b01, SC_RUN = 2'b10} cmoh_scan_e;
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} cmoh_tx_e;

endpackage : cmoh_pkg

// ===== test/cmoh_message_handler_sva.sv
// cmoh_message_handler_sva: port-level checker for the message handler
// assumes one clock, bound onto every cmoh_message_handler instance
`timescale 1ns/1ns
module cmoh_message_handler_sva #(
    parameter int NUM_OBJ = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic txLoadReady,
    input wire logic txStart,
    input wire cmoh_pkg::cmoh_frame_s txFrame,
    input wire logic txDone,
    input wire logic txFail,
    input wire logic [NUM_OBJ-1:0] irqPendingVec
);
    import cmoh_pkg::*;
    logic txBusy;
    logic next_txBusy;
    logic apbWr;
    logic crqWr;
    logic rdSetup;
    // ==========
    // helpers: frame on the core, bus phases
    assign next_txBusy = txStart || (txBusy && !txDone && !txFail);
    assign apbWr = psel && penable && pwrite;
    assign crqWr = apbWr && (paddr == OFS_CRQ);
    assign rdSetup = psel && !penable && !pwrite;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) txBusy <= 1'b0;
        else txBusy <= next_txBusy;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ==========
    // properties
    property p_rx_take; rxValid && rxReady |=> !rxReady; endproperty
    a_rx_take: assert property (p_rx_take) else $error("taken frame not scanned");
    property p_scan_end; $fell(rxReady) |-> ##[1:33] rxReady; endproperty
    a_scan_end: assert property (p_scan_end) else $error("scan too long");
    property p_tx_once; txStart |-> !txBusy; endproperty
    a_tx_once: assert property (p_tx_once) else $error("load while on the bus");
    property p_tx_load; txStart |-> $past(txLoadReady) && !$past(crqWr); endproperty
    a_tx_load: assert property (p_tx_load) else $error("load without free core");
    property p_tx_hold; !txStart |-> $stable(txFrame); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("frame changed between loads");
    property p_irq_set; |(irqPendingVec & ~$past(irqPendingVec)) |->
        $past(txDone) || !$past(rxReady) || $past(apbWr); endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq pending without cause");
    property p_irq_clr; |(~irqPendingVec & $past(irqPendingVec)) |-> $past(apbWr); endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq pending cleared by hardware");
    property p_rd_hold; !$past(rdSetup) |-> $stable(prdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : cmoh_message_handler_sva
bind cmoh_message_handler cmoh_message_handler_sva #(.NUM_OBJ(NUM_OBJ)) u_sva (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .rxValid(rxValid), .rxReady(rxReady),
    .txLoadReady(txLoadReady), .txStart(txStart), .txFrame(txFrame), .txDone(txDone),
    .txFail(txFail), .irqPendingVec(irqPendingVec));

// ===== test/cmoh_can_node.sv
// cmoh_can_node: behavioural protocol core standing for the other nodes
// assumes the handler clock; the bench offers frames through send()
`timescale 1ns/1ns
module cmoh_can_node (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] lag,
    input wire logic failNext,
    input wire logic txStart,
    output logic txLoadReady,
    output logic txDone,
    output logic txFail,
    output logic rxValid,
    output cmoh_pkg::cmoh_frame_s rxFrame,
    input wire logic rxReady
);
    import cmoh_pkg::*;
    logic [8:0] cnt;
    initial rxValid = 1'b0;
    initial rxFrame = '0;
    // ==========
    // receive side: frame held until taken, then junk
    task automatic send(input cmoh_frame_s f);
        rxFrame <= f;
        rxValid <= 1'b1;
        @(posedge clk);
        while (rxValid) @(posedge clk);
    endtask : send
    always @(posedge clk) begin
        if (rxValid && rxReady) begin
            rxValid <= 1'b0;
            rxFrame <= ~rxFrame;
        end
    end
    // ==========
    // transmit side: bus time of lag+1 cycles, optional lost arbitration
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            {txLoadReady, txDone, txFail, cnt} <= '0;
        end else begin
            txDone <= 1'b0;
            txFail <= 1'b0;
            if (txStart) begin
                txLoadReady <= 1'b0;
                cnt <= {1'b0, lag} + 9'd1;
            end else if (cnt == 9'd1) begin
                txDone <= !failNext;
                txFail <= failNext;
                cnt <= '0;
            end else if (cnt != '0) cnt <= cnt - 9'd1;
            else txLoadReady <= 1'b1;
        end
    end
endmodule : cmoh_can_node

// ===== test/testbench.sv
// testbench: apb driver, result queues and scenarios for the handler
// assumes cmoh_can_node as far side and the bound checker
`timescale 1ns/1ns
module testbench;
    import cmoh_pkg::*;
    logic clk = 1'b0, reset_n, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, failNext = 1'b0;
    logic [7:0] paddr = '0, lag = 8'd100;
    logic [31:0] pwdata = '0, prdata, irqPendingVec, seed = 32'h8;
    logic pready, pslverr, rxValid, rxReady, txLoadReady, txStart, txDone, txFail;
    cmoh_frame_s rxFrame, txFrame;
    logic [98:0] rq[$], tq[$];
    logic [63:0] dat[5];
    int bad_count = 0, tests_run = 0, ord[4] = '{3, 1, 2, 3};
    always #5 clk = ~clk;
    cmoh_message_handler #(.NUM_OBJ(32)) dut (.clk(clk), .reset_n(reset_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxFrame(rxFrame),
        .rxReady(rxReady), .txLoadReady(txLoadReady), .txStart(txStart), .txFrame(txFrame),
        .txDone(txDone), .txFail(txFail), .irqPendingVec(irqPendingVec));
    cmoh_can_node node (.clk(clk), .reset_n(reset_n), .lag(lag), .failNext(failNext),
        .txStart(txStart), .txLoadReady(txLoadReady), .txDone(txDone), .txFail(txFail),
        .rxValid(rxValid), .rxFrame(rxFrame), .rxReady(rxReady));
    // ==========
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [10:0] idf(input int n);
        return (n == 4) ? 11'h055 : 11'h100 + 11'(n);
    endfunction : idf
    function automatic logic [98:0] frm(input int n, input logic rtr);
        return {idf(n), 18'h0, 1'b0, rtr, 4'h8, dat[n]};
    endfunction : frm
    task automatic chk(input logic [98:0] g, input logic [98:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic summarize();
        if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(99'(e));
        apb(1'b0, a, '0);
    endtask : rd
    task automatic get(input int n);
        apb(1'b1, OFS_CMSK, 32'h7f);
        apb(1'b1, OFS_CRQ, 32'(n));
    endtask : get
    task automatic obj(input int n, input logic dir, input logic [15:0] mc);
        apb(1'b1, OFS_ARB1, '0);
        apb(1'b1, OFS_ARB2, {16'h0, 1'b1, 1'b0, dir, idf(n), 2'b0});
        apb(1'b1, OFS_MCTL, {16'h0, mc});
        for (int i = 0; i < 4; i++) apb(1'b1, OFS_DL1 + 8'(4 * i), {16'h0, dat[n][16*i+:16]});
        apb(1'b1, OFS_CMSK, 32'hb3);
        apb(1'b1, OFS_CRQ, 32'(n));
    endtask : obj
    task automatic drain();
        while (tq.size() != 0) @(posedge clk);
        @(posedge clk);
        while (!txLoadReady) @(posedge clk);
    endtask : drain
    // ==========
    // monitor: oldest note against each result
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) chk({66'h0, pslverr, prdata}, rq.pop_front());
        if (txStart) chk(txFrame, (tq.size() != 0) ? tq.pop_front() : 'x);
    end
    initial begin
        #50000;
        bad_count++;
        summarize();
    end
    // ==========
    // scenarios
    initial begin
        reset_n = 1'b0;
        for (int i = 0; i < 5; i++) dat[i] = {rnd(), rnd()};
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h30, {1'b1, 32'h0});
        failNext <= 1'b1;
        for (int k = 0; k < 4; k++) tq.push_back(frm(ord[k], 1'b0));
        for (int k = 0; k < 3; k++) obj(ord[k], 1'b1, (ord[k] == 1) ? 16'h0b88 : 16'h0988);
        while (!txFail) @(posedge clk);
        failNext <= 1'b0;
        lag <= 8'd4;
        drain();
        for (int k = 0; k < 3; k++) begin
            get(ord[k]);
            rd(OFS_MCTL, {17'h0, (ord[k] == 1) ? 16'h2a88 : 16'h2888});
            get(ord[k]);
            rd(OFS_MCTL, {17'h0, (ord[k] == 1) ? 16'h0a88 : 16'h0888});
        end
        obj(4, 1'b0, 16'h0488);
        node.send({idf(4), 18'h2abcd, 2'b0, 4'h8, dat[4]});
        node.send({idf(4), 18'h2abcd, 2'b0, 4'h8, dat[0]});
        while (!rxReady) @(posedge clk);
        get(4);
        rd(OFS_MCTL, {17'h0, 16'he488});
        rd(OFS_ARB1, 33'h0);
        rd(OFS_DH2, {17'h0, dat[0][63:48]});
        rd(OFS_DL1, {17'h0, dat[0][15:0]});
        tq.push_back(frm(1, 1'b0));
        node.send(frm(1, 1'b1));
        drain();
        summarize();
    end
endmodule : testbench
